// *** inc/blc_map.svh ***
/*
  Register offsets, field positions, reset values and limits of the bias,
  lead-detect and channel settings bank.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define BLC_IDX_BIAS_REF      8'h03
`define BLC_IDX_LEAD_DET      8'h04
`define BLC_IDX_CHAN_FIRST    8'h05
`define BLC_IDX_CHAN_LAST     8'h0C
`define BLC_IDX_DETECT_EN     8'h20
`define BLC_IDX_STATUS        8'h21

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BLC_RST_BIAS_REF      8'h40
`define BLC_RST_LEAD_DET      8'h00
`define BLC_RST_CHAN          8'h00
`define BLC_RST_DETECT_EN     16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BLC_BIAS_REFBUF_BIT   7
`define BLC_BIAS_RSVD_BIT     6
`define BLC_BIAS_REFHI_BIT    5
`define BLC_BIAS_MEAS_BIT     4
`define BLC_BIAS_REFINT_BIT   3
`define BLC_BIAS_BUF_BIT      2
`define BLC_BIAS_SENSE_BIT    1
`define BLC_BIAS_FLAG_BIT     0
`define BLC_CHAN_RSVD_BIT     3

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define BLC_MUX_BIAS_MEAS     3'h2
`define BLC_MUX_SHORTED       3'h1
`define BLC_FREQ_AC           2'h1
`define BLC_FREQ_BAD          2'h2
`define BLC_FREQ_DC           2'h3
`define BLC_GAIN_UNDEF        3'h7

`endif

// *** inc/blc_pkg.sv ***
/*
  Types for the bias, lead-detect and channel settings bank.
  Assumes blc_map.svh is on the include path.
*/
package blc_pkg;
  `include "blc_map.svh"

  // Bias and reference configuration layout
  typedef struct packed {
    logic ref_buffer_on;
    logic reserved_one;
    logic ref_high_select;
    logic bias_drive_measure;
    logic bias_ref_internal;
    logic bias_buffer_on;
    logic bias_sense_on;
    logic bias_detached_flag;
  } blc_bias_s;

  // Lead-detect control layout
  typedef struct packed {
    logic [2:0] detect_threshold;
    logic       detect_resistor_mode;
    logic [1:0] detect_current_level;
    logic [1:0] detect_frequency;
  } blc_lead_s;

  // Per-channel settings layout
  typedef struct packed {
    logic       channel_powerdown;
    logic [2:0] channel_gain;
    logic       reserved_zero;
    logic [2:0] channel_input_select;
  } blc_chan_s;

  // Input source codes
  typedef enum logic [2:0] {
    BLC_SRC_ELECTRODE = 3'b000,
    BLC_SRC_SHORTED   = 3'b001,
    BLC_SRC_BIAS_MEAS = 3'b010,
    BLC_SRC_SUPPLY    = 3'b011,
    BLC_SRC_TEMP      = 3'b100,
    BLC_SRC_TEST      = 3'b101,
    BLC_SRC_DRIVE_POS = 3'b110,
    BLC_SRC_DRIVE_NEG = 3'b111
  } blc_src_e;

  // APB slave phase
  typedef enum logic [1:0] {
    BLC_ST_IDLE   = 2'b00,
    BLC_ST_ACCESS = 2'b01
  } blc_state_e;

  // Analog control bundle leaving the block
  typedef struct packed {
    logic       ref_buffer_on;
    logic       ref_high_select;
    logic       bias_ref_internal;
    logic       bias_buffer_on;
    logic       bias_sense_on;
    logic [2:0] detect_threshold;
    logic       detect_resistor_mode;
    logic [1:0] detect_current_level;
    logic       detect_ac_on;
    logic       detect_dc_on;
  } blc_analog_s;
endpackage

// *** rtl/blc_chan_bank.sv ***
/*
  Bank of per-channel settings registers, one byte per channel, read data
  registered.
  Assumes writes come from the bus slave one cycle wide, synchronous reset.
*/
`timescale 1ns/1ns
`include "blc_map.svh"
module blc_chan_bank
  import blc_pkg::*;
#(
  parameter int N_CHAN = 8
)
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // Write port
  input  wire logic                       wr_en,
  input  wire logic [$clog2(N_CHAN)-1:0]  wr_sel,
  input  wire logic [7:0]                 wr_data,
  // Read port
  input  wire logic [$clog2(N_CHAN)-1:0]  rd_sel,
  output logic      [7:0]                 rd_data,
  // Live contents
  output blc_chan_s [N_CHAN-1:0]          chan_q
);

  // Elaboration check: the select is at most three bits wide
  if (N_CHAN < 2 || N_CHAN > 8)
  begin : g_bad_chan
    $error("blc_chan_bank: N_CHAN must be 2 to 8");
  end

  // ----------------------------------------------------------------------
  // Storage, one register per channel
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_CHAN; gi++)
    begin : g_chan
      always_ff @(posedge sys_clk)
      begin
        if (!resetn)
          chan_q[gi] <= blc_chan_s'(`BLC_RST_CHAN);
        else if (wr_en && int'(wr_sel) == gi)
          chan_q[gi] <= blc_chan_s'(wr_data);
      end
    end
  endgenerate

  // Registered read so the bus sees a flop, not a mux
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rd_data <= 8'h00;
    else
      rd_data <= chan_q[rd_sel];
  end

endmodule // blc_chan_bank

// *** rtl/blc_regs.sv ***
/*
  Bias/reference, lead-detect and channel settings register bank behind an
  APB slave, with decoded analog controls and per-channel routing.
  Assumes an APB master on sys_clk, a bias-electrode comparator level on
  bias_detached_in, synchronous active-low reset.
*/
// Added by the designer: register access over APB.
// Behaviour
// - bias reference config at index 03h, resets to 40h
// - bit 7 turns reference buffer on when one, off when zero
// - bit 5 selects high reference; host uses it only with 5 V supply
// - bit 4 routes bias return to channels selecting code 010
// - bit 3 picks internal mid-supply bias reference, else external
// - bit 2 turns bias buffer on when one
// - bit 1 turns bias electrode sense on when one
// - bit 0 reads one while bias electrode is detached, zero after reset
// - lead detect control at index 04h, resets to zero
// - bits 7:5 choose positive comparator threshold, 95 down to 70 percent
// - same field chooses negative threshold, 5 up to 30 percent
// - bit 4 selects resistor detection, else current source detection
// - bits 1:0: 01 AC, 11 DC, 10 forbidden
// - eight channel registers at indices 05h to 0Ch, reset zero
// - channel bit 7 powers channel down; software also selects shorted input
// - channel bits 2:0 select one of eight input sources
`timescale 1ns/1ns
`include "blc_map.svh"
module blc_regs
  import blc_pkg::*;
#(
  parameter int N_CHAN = 8
)
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Analog status
  input  wire logic                 bias_detached_in,
  // Analog controls
  output blc_analog_s               analog_q,
  output logic [N_CHAN-1:0]         channel_powerdown,
  output logic [3*N_CHAN-1:0]       channel_gain,
  output logic [3*N_CHAN-1:0]       channel_input_select,
  output logic [N_CHAN-1:0]         bias_return_route,
  output logic [N_CHAN-1:0]         positive_detect_enables,
  output logic [N_CHAN-1:0]         negative_detect_enables,
  // Software hazard flags
  output logic                      cfg_warn_q
);

  localparam int SW = $clog2(N_CHAN);

  // Elaboration check: enable bytes and channel select hold at most eight
  if (N_CHAN < 2 || N_CHAN > 8)
  begin : g_bad_chan
    $error("blc_regs: N_CHAN must be 2 to 8");
  end

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Word index from byte address; misaligned or high addresses map to nothing
  // High half is refused so no address above it aliases a register
  function automatic logic [8:0] word_idx(input logic [11:0] a);
    word_idx = (a[1:0] == 2'b00 && !a[11]) ? a[10:2] : 9'h1FF;
  endfunction

  // True for any channel register index
  function automatic logic is_chan(input logic [8:0] idx);
    is_chan = (idx >= {1'b0, `BLC_IDX_CHAN_FIRST}) &&
              (idx <  {1'b0, `BLC_IDX_CHAN_FIRST} + 9'(N_CHAN));
  endfunction

  // Channel number for a channel index
  function automatic logic [SW-1:0] chan_num(input logic [8:0] idx);
    logic [8:0] d;
    d = idx - {1'b0, `BLC_IDX_CHAN_FIRST};
    chan_num = d[SW-1:0];
  endfunction

  // True for any mapped index
  function automatic logic is_mapped(input logic [8:0] idx);
    is_mapped = (idx == {1'b0, `BLC_IDX_BIAS_REF}) ||
                (idx == {1'b0, `BLC_IDX_LEAD_DET}) ||
                (idx == {1'b0, `BLC_IDX_DETECT_EN}) ||
                (idx == {1'b0, `BLC_IDX_STATUS}) || is_chan(idx);
  endfunction

  // ----------------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------------
  blc_state_e  state_q;
  logic [8:0]  idx;
  logic        wr_fire;
  logic        rd_fire;
  logic        lane0;

  assign idx     = word_idx(paddr);
  assign lane0   = pstrb[0];
  // Answer in the first access cycle: zero wait states
  assign pready  = (state_q == BLC_ST_ACCESS);
  assign wr_fire = psel && penable && pready && pwrite;
  // Every setup latches the index, so a write never shows stale read data
  assign rd_fire = psel && !penable;

  // Setup starts a transfer, access completes it
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      state_q <= BLC_ST_IDLE;
    else
    begin
      case (state_q)
        BLC_ST_IDLE:   state_q <= (psel && !penable) ? BLC_ST_ACCESS : BLC_ST_IDLE;
        BLC_ST_ACCESS: state_q <= BLC_ST_IDLE;
        default:       state_q <= BLC_ST_IDLE;
      endcase
    end
  end

  // Unmapped or misaligned addresses answer with an error, no side effects
  assign pslverr = pready && psel && penable && !is_mapped(idx);

  // ----------------------------------------------------------------------
  // Bias and reference configuration
  // ----------------------------------------------------------------------
  blc_bias_s bias_q;
  logic      bias_flag_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      bias_q <= blc_bias_s'(`BLC_RST_BIAS_REF);
    else if (wr_fire && lane0 && idx == {1'b0, `BLC_IDX_BIAS_REF})
    begin
      bias_q <= blc_bias_s'(pwdata[7:0]);
      bias_q.bias_detached_flag <= 1'b0;
    end
  end

  // Status follows the comparator; software cannot write it
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      bias_flag_q <= 1'b0;
    else
      bias_flag_q <= bias_detached_in;
  end

  // ----------------------------------------------------------------------
  // Lead-detect control and per-input enables
  // ----------------------------------------------------------------------
  blc_lead_s   lead_q;
  logic [15:0] det_en_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      lead_q <= blc_lead_s'(`BLC_RST_LEAD_DET);
    else if (wr_fire && lane0 && idx == {1'b0, `BLC_IDX_LEAD_DET})
      lead_q <= blc_lead_s'(pwdata[7:0]);
  end

  // Positive enables in byte 0, negative in byte 1
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      det_en_q <= `BLC_RST_DETECT_EN;
    else if (wr_fire && idx == {1'b0, `BLC_IDX_DETECT_EN})
    begin
      if (pstrb[0])
        det_en_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        det_en_q[15:8] <= pwdata[15:8];
    end
  end

  assign positive_detect_enables = det_en_q[N_CHAN-1:0];
  assign negative_detect_enables = det_en_q[8 +: N_CHAN];

  // ----------------------------------------------------------------------
  // Channel settings bank
  // ----------------------------------------------------------------------
  blc_chan_s [N_CHAN-1:0] chan_q;
  logic [7:0]             chan_rd;

  blc_chan_bank #(
    .N_CHAN (N_CHAN)
  ) u_bank (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .wr_en   (wr_fire && lane0 && is_chan(idx)),
    .wr_sel  (chan_num(idx)),
    .wr_data (pwdata[7:0]),
    .rd_sel  (chan_num(idx)),
    .rd_data (chan_rd),
    .chan_q  (chan_q)
  );

  // ----------------------------------------------------------------------
  // Hazard flags: writes that break what software must keep
  // ----------------------------------------------------------------------
  // Bit 0 bias reserved, 1 channel reserved, 2 forbidden frequency,
  // 3 enables without valid frequency, 4 undefined gain
  logic [4:0] warn_sticky_q;
  logic [4:0] warn_now;
  logic       any_en;
  logic       gain_bad;
  logic       chan_rsvd;

  assign any_en = |{positive_detect_enables, negative_detect_enables};

  always_comb
  begin
    gain_bad  = 1'b0;
    chan_rsvd = 1'b0;
    for (int i = 0; i < N_CHAN; i++)
    begin
      gain_bad  = gain_bad  | (chan_q[i].channel_gain == `BLC_GAIN_UNDEF);
      chan_rsvd = chan_rsvd | chan_q[i].reserved_zero;
    end
  end

  assign warn_now[0] = !bias_q.reserved_one;
  assign warn_now[1] = chan_rsvd;
  assign warn_now[2] = (lead_q.detect_frequency == `BLC_FREQ_BAD);
  assign warn_now[3] = any_en && lead_q.detect_frequency != `BLC_FREQ_AC &&
                       lead_q.detect_frequency != `BLC_FREQ_DC;
  assign warn_now[4] = gain_bad;

  // Sticky; a new hazard in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      warn_sticky_q <= 5'h00;
    else if (wr_fire && lane0 && idx == {1'b0, `BLC_IDX_STATUS})
      warn_sticky_q <= (warn_sticky_q & ~pwdata[4:0]) | warn_now;
    else
      warn_sticky_q <= warn_sticky_q | warn_now;
  end

  // Live hazard level, no history kept
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      cfg_warn_q <= 1'b0;
    else
      cfg_warn_q <= |warn_now;
  end

  // ----------------------------------------------------------------------
  // Read index, captured in setup so it stands through the access cycle
  // ----------------------------------------------------------------------
  logic [8:0] rd_idx_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rd_idx_q <= 9'h000;
    else if (rd_fire)
      rd_idx_q <= idx;
  end

  // Channel data comes from the bank's read flop, same cycle timing
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_idx_q == {1'b0, `BLC_IDX_BIAS_REF})
      prdata[7:0] = {bias_q[7:1], bias_flag_q};
    else if (rd_idx_q == {1'b0, `BLC_IDX_LEAD_DET})
      prdata[7:0] = lead_q;
    else if (rd_idx_q == {1'b0, `BLC_IDX_DETECT_EN})
      prdata[15:0] = det_en_q;
    else if (rd_idx_q == {1'b0, `BLC_IDX_STATUS})
      prdata[4:0] = warn_sticky_q;
    else if (is_chan(rd_idx_q))
      prdata[7:0] = chan_rd;
  end

  // ----------------------------------------------------------------------
  // Analog control decode
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      analog_q <= '0;
    else
    begin
      analog_q.ref_buffer_on        <= bias_q.ref_buffer_on;
      analog_q.ref_high_select      <= bias_q.ref_high_select;
      analog_q.bias_ref_internal    <= bias_q.bias_ref_internal;
      analog_q.bias_buffer_on       <= bias_q.bias_buffer_on;
      analog_q.bias_sense_on        <= bias_q.bias_sense_on;
      analog_q.detect_threshold     <= lead_q.detect_threshold;
      analog_q.detect_resistor_mode <= lead_q.detect_resistor_mode;
      analog_q.detect_current_level <= lead_q.detect_current_level;
      // Forbidden code drives neither detector
      analog_q.detect_ac_on <= (lead_q.detect_frequency == `BLC_FREQ_AC);
      analog_q.detect_dc_on <= (lead_q.detect_frequency == `BLC_FREQ_DC);
    end
  end

  // Per-channel fields and bias return routing
  genvar gi;
  generate
    for (gi = 0; gi < N_CHAN; gi++)
    begin : g_out
      always_ff @(posedge sys_clk)
      begin
        if (!resetn)
        begin
          channel_powerdown[gi]          <= 1'b0;
          channel_gain[3*gi +: 3]        <= 3'h0;
          channel_input_select[3*gi +: 3] <= 3'h0;
          bias_return_route[gi]          <= 1'b0;
        end
        else
        begin
          channel_powerdown[gi]          <= chan_q[gi].channel_powerdown;
          channel_gain[3*gi +: 3]        <= chan_q[gi].channel_gain;
          channel_input_select[3*gi +: 3] <= chan_q[gi].channel_input_select;
          bias_return_route[gi]          <= bias_q.bias_drive_measure &&
                            chan_q[gi].channel_input_select == `BLC_MUX_BIAS_MEAS;
        end
      end
    end
  endgenerate

endmodule // blc_regs

// *** bench/blc_regs_asserts.sv ***
/*
  Port checker for the bias, lead-detect and channel settings bank.
  Assumes it is bound onto blc_regs: one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
module blc_regs_chk
  import blc_pkg::*;
#(
  parameter int N_CHAN = 8
)
(
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                resetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Analog side
  input wire logic                bias_detached_in,
  input wire blc_analog_s         analog_q,
  input wire logic [N_CHAN-1:0]   channel_powerdown,
  input wire logic [3*N_CHAN-1:0] channel_gain,
  input wire logic [3*N_CHAN-1:0] channel_input_select,
  input wire logic [N_CHAN-1:0]   bias_return_route
);
  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  wire logic acc  = psel && penable;
  wire logic wr_b = acc && pready && pwrite && pstrb[0];
  logic [N_CHAN-1:0] meas_sel;

  // Channels asking for the bias path
  always_comb
  begin
    for (int i = 0; i < N_CHAN; i++)
    begin
      meas_sel[i] = (channel_input_select[3*i +: 3] == 3'b010);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Outputs move one edge after the write edge; sampled values show it at ##2
  zero_wait_a: assert property (acc |-> pready)
    else $error("access cycle without ready");
  unmapped_err_a: assert property (acc && (paddr == 12'h000 || paddr == 12'h00D) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr >= 12'h00C && paddr <= 12'h030 && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("mapped access refused");
  ref_buffer_a: assert property (wr_b && paddr == 12'h00C |-> ##2 analog_q.ref_buffer_on == $past(pwdata[7], 2))
    else $error("reference buffer control wrong");
  ref_level_a: assert property (wr_b && paddr == 12'h00C |-> ##2
    {analog_q.ref_high_select, analog_q.bias_ref_internal} == {$past(pwdata[5], 2), $past(pwdata[3], 2)})
    else $error("reference select wrong");
  bias_buffer_a: assert property (wr_b && paddr == 12'h00C |-> ##2
    {analog_q.bias_buffer_on, analog_q.bias_sense_on} == $past(pwdata[2:1], 2))
    else $error("bias buffer or sense wrong");
  flag_read_a: assert property (acc && !pwrite && paddr == 12'h00C |->
    prdata[0] == $past(bias_detached_in) && prdata[31:8] == 24'h0)
    else $error("detached flag read wrong");
  thresh_mode_a: assert property (wr_b && paddr == 12'h010 |-> ##2
    {analog_q.detect_threshold, analog_q.detect_resistor_mode, analog_q.detect_current_level} == $past(pwdata[7:2], 2))
    else $error("lead detect fields wrong");
  freq_decode_a: assert property (wr_b && paddr == 12'h010 |-> ##2
    analog_q.detect_ac_on == ($past(pwdata[1:0], 2) == 2'b01) &&
    analog_q.detect_dc_on == ($past(pwdata[1:0], 2) == 2'b11))
    else $error("detect frequency decode wrong");
  chan_first_a: assert property (wr_b && paddr == 12'h014 |-> ##2
    {channel_powerdown[0], channel_gain[2:0], channel_input_select[2:0]} ==
    {$past(pwdata[7:4], 2), $past(pwdata[2:0], 2)})
    else $error("channel one outputs wrong");
  bias_route_a: assert property (|bias_return_route |-> (bias_return_route & ~meas_sel) == '0)
    else $error("bias route to channel not selecting it");
endmodule // blc_regs_chk

bind blc_regs blc_regs_chk #(.N_CHAN(N_CHAN)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bias_detached_in(bias_detached_in), .analog_q(analog_q), .channel_powerdown(channel_powerdown),
  .channel_gain(channel_gain), .channel_input_select(channel_input_select), .bias_return_route(bias_return_route)
);

// *** bench/blc_host_model.sv ***
/*
  Host model: APB master that programs the bank and keeps software duties other than avoiding the undefined gain code.
  Assumes one clock shared with the slave; requests start after reset release.
*/
`timescale 1ns/1ns
module blc_host_model
(
  // Clock
  input  wire logic        sys_clk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic det_on = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;

  // One transfer; released data is inverted so stale values never pass
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, wr, a, d, s};
    @(posedge sys_clk);
    penable <= 1'b1;
    while (!ok && n < 20)
    begin
      @(posedge sys_clk);
      n++;
      if (pready === 1'b1)
      begin
        ok = 1'b1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask

  // Values a careful driver writes
  function automatic logic [7:0] legal(input int idx, input logic [7:0] v);
    legal = v;
    if (idx == 3) legal[6] = 1'b1;
    if (idx == 4 && det_on && !v[0]) legal[1:0] = 2'b11;
    if (idx >= 5) legal[3] = 1'b0;
    if (idx >= 5 && v[7]) legal[2:0] = 3'b001;
  endfunction
endmodule // blc_host_model

// *** bench/blc_regs_test.sv ***
/*
  Self-checking bench of the register bank, random writes among corner cases.
  Assumes blc_pkg compiled first and the checker bound onto the design.
*/
`timescale 1ns/1ns
module blc_regs_test;
  import blc_pkg::*;
  logic        sys_clk;
  logic        resetn;
  logic        psel, penable, pwrite, pready, pslverr, bias_det, e, ok, warn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pstrb;
  logic [7:0]  sh [3:12];
  blc_analog_s analog_q;
  logic [7:0]  pd, route, pen, nen;
  logic [23:0] gain, sel;
  int          err_total, checked, idx;

  blc_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bias_detached_in(bias_det), .analog_q(analog_q), .channel_powerdown(pd), .channel_gain(gain),
    .channel_input_select(sel), .bias_return_route(route), .positive_detect_enables(pen),
    .negative_detect_enables(nen), .cfg_warn_q(warn));
  blc_host_model u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // Bus cycle; a hung slave ends the run
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    u_host.xfer(wr, a, d, s, v, e, ok);
    if (!ok)
    begin
      err_total++;
      report_and_stop();
    end
  endtask

  // Expected analog bundle from the shadow bytes
  function automatic blc_analog_s exp_an(input logic [7:0] b, input logic [7:0] l);
    exp_an = {b[7], b[5], b[3], b[2], b[1], l[7:2], l[1:0] == 2'b01, l[1:0] == 2'b11};
  endfunction

  // Expected hazard bits from the shadow bytes
  function automatic logic [4:0] exp_warn();
    exp_warn = {1'b0, u_host.det_on && !sh[4][0], sh[4][1:0] == 2'b10, 1'b0, !sh[3][6]};
    for (int i = 5; i <= 12; i++)
      exp_warn |= {sh[i][6:4] == 3'h7, 2'b00, sh[i][3], 1'b0};
  endfunction

  // Outputs settle one edge after the write edge
  task automatic check_outputs();
    @(posedge sys_clk);
    #1;
    chk("analog", 32'(exp_an(sh[3], sh[4])), 32'(analog_q));
    chk("warn", 32'(|exp_warn()), 32'(warn));
    for (int i = 0; i < 8; i++)
    begin
      chk("chan", 32'({sh[5+i][7:4], sh[5+i][2:0]}), 32'({pd[i], gain[3*i +: 3], sel[3*i +: 3]}));
      chk("route", 32'(sh[3][4] && sh[5+i][2:0] == 3'b010), 32'(route[i]));
    end
  endtask

  task automatic wr_reg(input int i, input logic [7:0] d);
    bus(1'b1, 12'(i*4), {24'h0, d}, 4'hF);
    sh[i] = d;
    check_outputs();
    bus(1'b0, 12'(i*4), 32'h0, 4'hF);
    chk("readback", (i == 3) ? {24'h0, d[7:1], bias_det} : {24'h0, d}, v);
  endtask

  initial
  begin
    {sys_clk, resetn, bias_det, err_total, checked} = '0;
    void'($urandom(14198));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset values of the bias, lead-detect and channel registers
    for (int i = 3; i <= 12; i++)
    begin
      bus(1'b0, 12'(i*4), 32'h0, 4'hF);
      chk("reset", (i == 3) ? 32'h40 : 32'h0, v);
      sh[i] = v[7:0];
    end
    // Refused places and a masked lane
    bus(1'b1, 12'h00D, 32'hFF, 4'hF);
    chk("misaligned err", 32'h1, 32'(e));
    bus(1'b1, 12'h014, 32'hFF, 4'hE);
    bus(1'b0, 12'h000, 32'h0, 4'hF);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, v);
    bus(1'b0, 12'h014, 32'h0, 4'hF);
    chk("masked write", 32'h0, v);
    // Every detect frequency, then random programming
    for (int k = 0; k < 4; k++) wr_reg(4, {6'($urandom), 2'(k)});
    // Detect enables on both sides; from here the host keeps the frequency legal
    bus(1'b1, 12'h080, 32'h0000_A55A, 4'h3);
    u_host.det_on = 1'b1;
    check_outputs();
    chk("enables", 32'h0000_A55A, {16'h0, nen, pen});
    bus(1'b0, 12'h080, 32'h0, 4'hF);
    chk("enables read", 32'h0000_A55A, v);
    for (int k = 0; k < 30; k++)
    begin
      idx = 3 + ($urandom % 10);
      wr_reg(idx, u_host.legal(idx, 8'($urandom)));
    end
    // Bias path routed to channel three, gain code boundary
    wr_reg(3, 8'h50);
    wr_reg(7, 8'h62);
    wr_reg(12, 8'h89);
    // Detached flag follows the comparator, not the host
    bias_det <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wr_reg(3, 8'hC7);
    bus(1'b0, 12'h00C, 32'h0, 4'hF);
    chk("flag set", 32'hC7, v);
    bias_det <= 1'b0;
    repeat (2) @(posedge sys_clk);
    bus(1'b0, 12'h00C, 32'h0, 4'hF);
    chk("flag clear", 32'hC6, v);
    // Clearing the sticky hazards leaves only those still present
    bus(1'b1, 12'h084, 32'h0000_001F, 4'hF);
    bus(1'b0, 12'h084, 32'h0, 4'hF);
    chk("status", 32'(exp_warn()), v);
    report_and_stop();
  end
endmodule // blc_regs_test
